// [design/drive_tune_pkg.sv]
package drive_tune_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned TUNE_HOLD_S = 4;
  localparam int unsigned RS_SKIP_S = 1;
  localparam int unsigned TUNE_HOLD_CYC = TUNE_HOLD_S * CLK_HZ;
  localparam int unsigned RS_SKIP_CYC = RS_SKIP_S * CLK_HZ;
  // ****************************************
  // Register map (byte offsets)
  // ****************************************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_RATED = 8'h04;
  localparam logic [7:0] A_MOTOR = 8'h08;
  localparam logic [7:0] A_CURR = 8'h0C;
  localparam logic [7:0] A_RS = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_MEAS1 = 8'h18;
  localparam logic [7:0] A_MEAS2 = 8'h1C;
  localparam logic [7:0] A_VOUT = 8'h20;
  localparam logic [7:0] A_IOUT = 8'h24;
  // CTRL fields and reset value (slip compensation on)
  localparam int CTL_SEL_LO = 0;
  localparam int CTL_MODE_LO = 2;
  localparam int CTL_DEN = 5;
  localparam int CTL_SLIP = 6;
  localparam int CTL_CWEN = 7;
  localparam int CTL_CWDIS = 8;
  localparam logic [8:0] CTRL_RST = 9'h040;
  localparam logic [7:0] PF_RST = 8'hD9;
  // ****************************************
  // Encodings and scaling
  // ****************************************
  localparam logic [1:0] SEL_STAT = 2'h1;
  localparam logic [1:0] SEL_ROT = 2'h2;
  localparam logic [2:0] VM_EVERY = 3'h0;
  localparam logic [2:0] VM_MANUAL = 3'h1;
  localparam logic [2:0] VM_FIXED = 3'h2;
  localparam logic [2:0] VM_ONCE = 3'h3;
  localparam logic [2:0] VM_PWRUP = 3'h4;
  localparam logic [2:0] VM_SQUARE = 3'h5;
  localparam logic [31:0] RS_FULL_DIV = 32'h32;
  localparam logic [31:0] RS_TAPER_DIV = 32'h4;
  localparam logic [31:0] BOOST_DIV = 32'h2;
  localparam logic [31:0] SEC_PER_MIN_DECI = 32'h6;
  localparam logic [31:0] LS_SCALE = 32'h0001_0000;
  localparam logic [8:0] GAIN_FULL = 9'h100;

  typedef enum logic [2:0] {K_RS, K_LTR, K_DTMAX, K_DTI, K_LS} meas_kind_e;
  typedef struct packed {logic valid; meas_kind_e kind;} meas_req_s;
  typedef struct packed {logic done; logic ok; logic [15:0] value;} meas_rsp_s;
endpackage

// [design/drive_autotune_voltage_mode.sv]
// Behaviour
// - Selector 1 stationary, 2 rotating; test starts with enable and run
// - Stationary test measures resistance, transient inductance, deadtime pair; keeps power factor
// - Rotating test: stationary first, ramp to 2/3 rated frequency, hold 4 s
// - Rotating test measures stator inductance and stores computed power factor
// - After any autotune, inhibit until a controlled disable is seen
// - Controlled disable: enable input low, enable bit 0, or control word disable
// - Vector modes: voltage linear to rated frequency, constant above
// - Full resistance compensation fr/50..fr/4, tapering to zero by fr/2
// - Mode codes 0 every,1 none,2 fixed,3 once,4 power-up,5 square
// - Every-run mode measures resistance each run, no nonvolatile save
// - Every-run mode skips measurement within 1 s of entering ready
// - Power-up mode measures only on first run after power-up, no save
// - No-measurement mode never measures; uses stored resistance setting
// - Once mode: success switches to none and saves; failure retries
// - Fixed modes ignore resistance; fixed is linear then constant
// - Square mode: square law to rated frequency, constant above
// - Fixed modes add boost from 0 Hz to half rated frequency
// - Slip compensation off when rated speed equals synchronous speed
// - Active and magnetising current from power factor and rated current
// - Rated slip = rated frequency minus pole pairs times speed over 60
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module drive_autotune_voltage_mode
  import drive_tune_pkg::*;
#(
  parameter int unsigned HOLD_CYC = TUNE_HOLD_CYC,
  parameter int unsigned SKIP_CYC = RS_SKIP_CYC
)(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Control terminals
  input wire logic enable_in,
  input wire logic run_in,
  // Ramp and measurement engine
  input wire logic [15:0] freq_now,
  input wire logic at_speed,
  input wire drive_tune_pkg::meas_rsp_s meas_rsp,
  output var drive_tune_pkg::meas_req_s meas_req,
  // Drive outputs
  output logic drive_run,
  output logic [15:0] freq_target,
  output logic nv_save,
  output logic [15:0] v_out,
  output logic [8:0] rs_gain,
  output logic slip_on
);
  import drive_tune_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_MEAS, S_ACCEL, S_HOLD, S_LS, S_RUN, S_INH} state_e;

  // ****************************************
  // Registers
  // ****************************************
  logic [8:0] ctrl;
  logic [31:0] rated;
  logic [31:0] motor;
  logic [15:0] rated_i;
  logic [7:0] pf;
  logic [15:0] rs;
  logic [15:0] ltr;
  logic [15:0] ls;
  logic [15:0] dt_max;
  logic [15:0] dt_i;
  logic [15:0] i_act;
  logic [15:0] i_mag;
  logic [15:0] slip_hz;
  logic pu_done;
  logic fail;
  state_e state;
  logic tuning;
  logic [31:0] cnt;
  logic [31:0] rdy_cnt;
  logic once_ok;
  logic pf_wr;
  logic [7:0] pf_new;

  wire logic [1:0] tune_sel = ctrl[CTL_SEL_LO +: 2];
  wire logic [2:0] vmode = ctrl[CTL_MODE_LO +: 3];
  wire logic [15:0] fr = rated[15:0];
  wire logic [15:0] nspd = rated[31:16];
  wire logic [15:0] vr = motor[15:0];
  wire logic [7:0] poles = motor[23:16];
  wire logic [7:0] boost = motor[31:24];
  wire logic wr = psel && penable && pwrite;

  // Combined enable; its absence is the controlled disable
  logic en_ok;
  assign en_ok = enable_in && ctrl[CTL_DEN] && !(ctrl[CTL_CWEN] && ctrl[CTL_CWDIS]);

  // ****************************************
  // APB slave: zero wait, data set up in setup phase
  // ****************************************
  logic mapped;
  logic [31:0] rd_mux;
  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      A_CTRL: rd_mux = {23'h0, ctrl};
      A_RATED: rd_mux = rated;
      A_MOTOR: rd_mux = motor;
      A_CURR: rd_mux = {8'h00, pf, rated_i};
      A_RS: rd_mux = {16'h0000, rs};
      A_STAT: rd_mux = {26'h0, fail, pu_done, tuning, state};
      A_MEAS1: rd_mux = {ls, ltr};
      A_MEAS2: rd_mux = {dt_i, dt_max};
      A_VOUT: rd_mux = {slip_hz, v_out};
      A_IOUT: rd_mux = {i_mag, i_act};
      default: mapped = 1'b0;
    endcase
  end

  assign pready = 1'b1;

  // Read data and error latched in setup so outputs come from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= !mapped;
    end
  end

  // Control register; the hardware mode switch wins over a software write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= CTRL_RST;
    else if (once_ok)
      ctrl[CTL_MODE_LO +: 3] <= VM_MANUAL;
    else if (wr && paddr == A_CTRL)
      ctrl <= pwdata[8:0];
  end

  // Plain motor settings
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rated <= 32'h0000_0000;
      motor <= 32'h0000_0000;
      rated_i <= 16'h0000;
    end
    else if (wr)
    begin
      if (paddr == A_RATED)
        rated <= pwdata;
      if (paddr == A_MOTOR)
        motor <= pwdata;
      if (paddr == A_CURR)
        rated_i <= pwdata[15:0];
    end
  end

  // Power factor: nameplate entry, replaced by the rotating test
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pf <= PF_RST;
    else if (pf_wr)
      pf <= pf_new;
    else if (wr && paddr == A_CURR)
      pf <= pwdata[23:16];
  end

  // ****************************************
  // Sequencer
  // ****************************************
  logic start;
  logic rs_need;
  logic m_fin;
  logic m_good;
  meas_kind_e kind;
  assign start = en_ok && run_in;
  assign m_fin = state == S_MEAS && meas_rsp.done;
  assign m_good = m_fin && meas_rsp.ok;
  // Every-run skips inside the settle window; manual and fixed never measure
  always_comb
  begin
    unique case (vmode)
      VM_EVERY: rs_need = rdy_cnt >= SKIP_CYC;
      VM_ONCE: rs_need = 1'b1;
      VM_PWRUP: rs_need = !pu_done;
      default: rs_need = 1'b0;
    endcase
  end

  // Ready window timer, restarted on each entry into ready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdy_cnt <= 32'h0000_0000;
    else if (!(state == S_IDLE && en_ok && !run_in))
      rdy_cnt <= 32'h0000_0000;
    else if (rdy_cnt < SKIP_CYC)
      rdy_cnt <= rdy_cnt + 32'h1;
  end

  // Main state machine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= S_IDLE;
      tuning <= 1'b0;
      kind <= K_RS;
      fail <= 1'b0;
    end
    else
    begin
      unique case (state)
        S_IDLE:
          if (start && (tune_sel == SEL_STAT || tune_sel == SEL_ROT))
          begin
            state <= S_MEAS;
            tuning <= 1'b1;
            kind <= K_RS;
            fail <= 1'b0;
          end
          else if (start && rs_need)
          begin
            state <= S_MEAS;
            tuning <= 1'b0;
            kind <= K_RS;
            fail <= 1'b0;
          end
          else if (start)
            state <= S_RUN;
        S_MEAS:
          if (!en_ok)
            state <= S_IDLE;
          else if (m_fin && !meas_rsp.ok)
          begin
            fail <= 1'b1;
            state <= tuning ? S_INH : S_IDLE;
          end
          else if (m_fin && !tuning)
            state <= S_RUN;
          else if (m_fin && kind == K_DTI)
            state <= tune_sel == SEL_ROT ? S_ACCEL : S_INH;
          else if (m_fin)
            kind <= meas_kind_e'(kind + 3'h1);
        S_ACCEL:
          if (!en_ok)
            state <= S_IDLE;
          else if (at_speed)
            state <= S_HOLD;
        S_HOLD:
          if (!en_ok)
            state <= S_IDLE;
          else if (cnt == HOLD_CYC - 1)
            state <= S_LS;
        S_LS:
          if (!en_ok)
            state <= S_IDLE;
          else if (meas_rsp.done)
          begin
            fail <= !meas_rsp.ok;
            state <= S_INH;
          end
        S_RUN:
          if (!start)
            state <= S_IDLE;
        S_INH:
          if (!en_ok)
          begin
            state <= S_IDLE;
            tuning <= 1'b0;
          end
      endcase
    end
  end

  // Hold timer for the rotating step
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt <= 32'h0000_0000;
    else if (state != S_HOLD)
      cnt <= 32'h0000_0000;
    else
      cnt <= cnt + 32'h1;
  end

  // Measurement requests follow the state
  assign meas_req.valid = state == S_MEAS || state == S_LS;
  assign meas_req.kind = state == S_LS ? K_LS : kind;
  assign drive_run = state == S_RUN || state == S_ACCEL || state == S_HOLD;
  assign freq_target = (state == S_ACCEL || state == S_HOLD) ?
    16'((32'(fr) * 32'h2) / 32'h3) : freq_now;

  // Power-up latch, cleared only by reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pu_done <= 1'b0;
    else if (m_good && kind == K_RS)
      pu_done <= 1'b1;
  end

  // Measured values; success in once mode saves value and mode together
  assign once_ok = m_good && !tuning && vmode == VM_ONCE;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rs <= 16'h0000;
      ltr <= 16'h0000;
      dt_max <= 16'h0000;
      dt_i <= 16'h0000;
      ls <= 16'h0000;
      nv_save <= 1'b0;
    end
    else
    begin
      nv_save <= once_ok;
      if (m_good && kind == K_RS)
        rs <= meas_rsp.value;
      else if (wr && paddr == A_RS)
        rs <= pwdata[15:0];
      if (m_good && kind == K_LTR)
        ltr <= meas_rsp.value;
      if (m_good && kind == K_DTMAX)
        dt_max <= meas_rsp.value;
      if (m_good && kind == K_DTI)
        dt_i <= meas_rsp.value;
      if (state == S_LS && meas_rsp.done && meas_rsp.ok)
        ls <= meas_rsp.value;
    end
  end

  // ****************************************
  // Motor arithmetic
  // ****************************************
  function automatic logic [15:0] isqrt(input logic [31:0] x);
    logic [31:0] r;
    logic [31:0] b;
    logic [31:0] v;
    r = 32'h0;
    b = 32'h4000_0000;
    v = x;
    for (int i = 0; i < 16; i++)
    begin
      if (v >= r + b)
      begin
        v = v - (r + b);
        r = (r >> 1) + b;
      end
      else
        r = r >> 1;
      b = b >> 2;
    end
    return r[15:0];
  endfunction

  // Power factor from inductance: cos = sqrt(1 - (Imag/I)^2), Q8
  logic [31:0] im_ls;
  logic [31:0] ratio;
  always_comb
  begin
    im_ls = (fr == 16'h0 || meas_rsp.value == 16'h0) ? 32'h0 :
      (32'(vr) * LS_SCALE) / (32'(fr) * 32'(meas_rsp.value));
    ratio = rated_i == 16'h0 ? 32'h0 : (im_ls << 8) / 32'(rated_i);
    if (ratio > 32'hFF)
      ratio = 32'hFF;
    pf_new = 8'(isqrt(32'h1_0000 - ratio * ratio));
    pf_wr = state == S_LS && meas_rsp.done && meas_rsp.ok && en_ok;
  end

  // Active and magnetising currents, rated slip
  logic [31:0] act;
  logic [31:0] slip_d;
  logic [31:0] syn;
  always_comb
  begin
    act = (32'(rated_i) * 32'(pf)) >> 8;
    syn = 32'(poles >> 1) * 32'(nspd);
    slip_d = syn / SEC_PER_MIN_DECI;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      i_act <= 16'h0000;
      i_mag <= 16'h0000;
      slip_hz <= 16'h0000;
      slip_on <= 1'b0;
    end
    else
    begin
      i_act <= act[15:0];
      i_mag <= isqrt(32'(rated_i) * 32'(rated_i) - act * act);
      slip_hz <= 16'(32'(fr) - slip_d);
      // Speed 0 or synchronous means no slip to correct
      slip_on <= ctrl[CTL_SLIP] && nspd != 16'h0 &&
        syn != 32'(fr) * SEC_PER_MIN_DECI;
    end
  end

  // ****************************************
  // Voltage characteristic
  // ****************************************
  logic vec;
  logic [31:0] f;
  logic [31:0] fr32;
  logic [31:0] v_lin;
  logic [31:0] v_sq;
  logic [31:0] v_sel;
  logic [31:0] g;
  always_comb
  begin
    vec = vmode == VM_EVERY || vmode == VM_MANUAL || vmode == VM_ONCE || vmode == VM_PWRUP;
    f = 32'(freq_now);
    fr32 = 32'(fr);
    v_lin = (fr32 == 32'h0 || f >= fr32) ? 32'(vr) : (32'(vr) * f) / fr32;
    // Square law divides twice to keep the product within 32 bits
    v_sq = (fr32 == 32'h0 || f >= fr32) ? 32'(vr) : ((v_lin * f) / fr32);
    v_sel = vmode == VM_SQUARE ? v_sq : v_lin;
    if (!vec && f * BOOST_DIV <= fr32)
      v_sel = v_sel + 32'(boost);
    g = 32'h0;
    if (vec && f * RS_FULL_DIV >= fr32 && f * RS_TAPER_DIV < fr32)
      g = 32'(GAIN_FULL);
    else if (vec && f * RS_TAPER_DIV >= fr32 && f * BOOST_DIV < fr32)
      g = ((fr32 - f * BOOST_DIV) * 32'(GAIN_FULL) * BOOST_DIV) / fr32;
  end

  // Fixed modes get no resistance compensation at all
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      v_out <= 16'h0000;
      rs_gain <= 9'h000;
    end
    else
    begin
      v_out <= v_sel[15:0];
      rs_gain <= g[8:0];
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_tune_start: assert property (@(posedge pclk) disable iff (!presetn)
    state == S_IDLE && start && tune_sel == SEL_ROT |=> state == S_MEAS && tuning)
    else $error("rotating tune did not start");
  a_stat_end: assert property (@(posedge pclk) disable iff (!presetn)
    m_good && tuning && kind == K_DTI && tune_sel == SEL_STAT && en_ok |=> state == S_INH)
    else $error("stationary tune did not end in inhibit");
  a_hold_len: assert property (@(posedge pclk) disable iff (!presetn)
    state == S_HOLD && $past(state) != S_HOLD && en_ok |-> cnt == 32'h0)
    else $error("hold timer not restarted");
  a_pf_store: assert property (@(posedge pclk) disable iff (!presetn)
    pf_wr |=> pf == $past(pf_new))
    else $error("power factor not stored");
  a_inh_stay: assert property (@(posedge pclk) disable iff (!presetn)
    state == S_INH && en_ok |=> state == S_INH && !drive_run)
    else $error("inhibit left without disable");
  a_disable_exit: assert property (@(posedge pclk) disable iff (!presetn)
    state == S_INH && !en_ok |=> state == S_IDLE)
    else $error("controlled disable ignored");
  a_skip_window: assert property (@(posedge pclk) disable iff (!presetn)
    state == S_IDLE && start && tune_sel == 2'h0 && vmode == VM_EVERY &&
    rdy_cnt < SKIP_CYC |=> state == S_RUN)
    else $error("measured inside settle window");
  a_manual_none: assert property (@(posedge pclk) disable iff (!presetn)
    state == S_IDLE && tune_sel == 2'h0 && vmode == VM_MANUAL |=> state != S_MEAS)
    else $error("manual mode measured");
  a_once_save: assert property (@(posedge pclk) disable iff (!presetn)
    once_ok |=> nv_save && vmode == VM_MANUAL ##1 !nv_save)
    else $error("once mode did not save and switch");
  a_fixed_gain: assert property (@(posedge pclk) disable iff (!presetn)
    !vec |=> rs_gain == 9'h000)
    else $error("fixed mode compensated");
  a_slip_off: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl[CTL_SLIP] || nspd == 16'h0 |=> !slip_on)
    else $error("slip compensation on while disabled");
  c_rot_tune: cover property (@(posedge pclk) disable iff (!presetn)
    state == S_LS ##1 state == S_INH);
  c_once_ok: cover property (@(posedge pclk) disable iff (!presetn) once_ok);
  c_run: cover property (@(posedge pclk) disable iff (!presetn)
    state == S_IDLE ##1 state == S_RUN);
  c_taper: cover property (@(posedge pclk) disable iff (!presetn)
    rs_gain != 9'h000 && rs_gain != GAIN_FULL);
endmodule // drive_autotune_voltage_mode
`default_nettype wire

// [verification/drive_motor_model.sv]
`timescale 1ns/100ps
`default_nettype none
module drive_motor_model
  import drive_tune_pkg::*;
#(
  parameter int unsigned MEAS_DLY = 5
)(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench commands
  input wire logic meas_fail,
  input wire logic jog,
  input wire logic [15:0] f_ref,
  // Drive side
  input wire logic drive_run,
  input wire logic [15:0] freq_target,
  input wire drive_tune_pkg::meas_req_s meas_req,
  output var drive_tune_pkg::meas_rsp_s meas_rsp,
  output logic [15:0] freq_now,
  output logic at_speed
);
  int unsigned cnt;
  int unsigned n_meas;
  logic [2:0] last;
  // ****************************************
  // Measurement engine
  // ****************************************
  // One answer per request; stale answer lines keep toggling
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 0;
      n_meas <= 0;
      last <= 3'h0;
      meas_rsp <= '0;
    end
    else
    begin
      last <= meas_req.kind;
      meas_rsp.done <= 1'b0;
      meas_rsp.ok <= ~meas_rsp.ok;
      meas_rsp.value <= ~meas_rsp.value;
      if (!meas_req.valid || meas_req.kind != last)
        cnt <= 0;
      else if (cnt < MEAS_DLY)
        cnt <= cnt + 1;
      else if (cnt == MEAS_DLY)
      begin
        meas_rsp.done <= 1'b1;
        meas_rsp.ok <= !meas_fail;
        meas_rsp.value <= 16'h0100 + 16'h0011 * meas_req.kind;
        cnt <= cnt + 1;
        n_meas <= n_meas + 1;
      end
    end
  end
  // Ramp: bench reference when jogging, zero when not running, else one step a cycle to target
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      freq_now <= '0;
    else if (jog)
      freq_now <= f_ref;
    else if (!drive_run)
      freq_now <= '0;
    else if (freq_now < freq_target)
      freq_now <= freq_now + 16'h0001;
    else if (freq_now > freq_target)
      freq_now <= freq_now - 16'h0001;
  end
  assign at_speed = drive_run && (freq_now == freq_target);
endmodule // drive_motor_model
`default_nettype wire

// [verification/drive_autotune_voltage_mode_test.sv]
`timescale 1ns/100ps
`default_nettype none
module drive_autotune_voltage_mode_test;
  import drive_tune_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, enable_in, run_in;
  logic at_speed, drive_run, nv_save, slip_on, meas_fail, jog, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [15:0] freq_now, freq_target, v_out, f_ref;
  logic [8:0] rs_gain;
  meas_req_s meas_req;
  meas_rsp_s meas_rsp;
  int miscompares, comparisons, nv_cnt, n0, i, n;
  // Mode, frequency, volts, gain at fr 600, 400 V, 20 V boost
  logic [47:0] vtab [15] = '{48'h001_009_006_000, 48'h001_00C_008_100, 48'h001_093_062_100,
    48'h001_096_064_100, 48'h001_0E1_096_080, 48'h001_12C_0C8_000, 48'h001_384_190_000,
    48'h000_0E1_096_080, 48'h003_0E1_096_080, 48'h004_0E1_096_080, 48'h002_12C_0DC_000,
    48'h002_12F_0CA_000, 48'h005_12C_078_000, 48'h005_1C2_0E1_000, 48'h005_384_190_000};
  // ****************************************
  // Design and motor
  // ****************************************
  drive_autotune_voltage_mode #(.HOLD_CYC(20), .SKIP_CYC(10)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enable_in(enable_in), .run_in(run_in), .freq_now(freq_now), .at_speed(at_speed),
    .meas_rsp(meas_rsp), .meas_req(meas_req), .drive_run(drive_run),
    .freq_target(freq_target), .nv_save(nv_save), .v_out(v_out), .rs_gain(rs_gain),
    .slip_on(slip_on));
  drive_motor_model pm (.pclk(pclk), .presetn(presetn), .meas_fail(meas_fail), .jog(jog),
    .f_ref(f_ref), .drive_run(drive_run), .freq_target(freq_target), .meas_req(meas_req),
    .meas_rsp(meas_rsp), .freq_now(freq_now), .at_speed(at_speed));
  // Clock and save-pulse counter
  always #2 pclk = ~pclk;
  always @(posedge pclk) if (nv_save === 1'b1) nv_cnt <= nv_cnt + 1;
  // ****************************************
  // Helpers
  // ****************************************
  task automatic stop_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge pclk);
  endtask
  // Idle edge first so psel never changes twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pins(input logic en, input logic run);
    @(posedge pclk);
    enable_in <= en;
    run_in <= run;
  endtask
  task automatic wait_st(input logic [2:0] s);
    apb(0, A_STAT, 0);
    for (int j = 0; j < 400 && rdata[2:0] !== s; j++) apb(0, A_STAT, 0);
    chk("state", rdata[2:0], s);
  endtask
  task automatic cfg(input logic [15:0] fr, input logic [15:0] spd);
    apb(1, A_RATED, {spd, fr});
    apb(1, A_MOTOR, 32'h1404_0190);
    apb(1, A_CURR, 32'h00D9_010C);
    apb(1, A_RS, 0);
  endtask
  task automatic tune(input logic [31:0] c);
    apb(1, A_CTRL, c);
    pins(1, 1);
    wait_st(3'h6);
    pins(1, 0);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_stat;
    cfg(600, 1470);
    n0 = pm.n_meas;
    tune(32'h61);
    chk("meas count", pm.n_meas - n0, 4);
    apb(0, A_RS, 0);
    chk("rs", rdata, 32'h0100);
    apb(0, A_MEAS1, 0);
    chk("ltr", rdata[15:0], 16'h0111);
    apb(0, A_MEAS2, 0);
    chk("deadtime", rdata, 32'h0133_0122);
    apb(0, A_CURR, 0);
    chk("pf kept", rdata[23:16], 8'hD9);
    pins(1, 1);
    step(8);
    chk("inhibit run", drive_run, 0);
    pins(0, 0);
    wait_st(3'h0);
  endtask
  task automatic t_rot;
    n0 = pm.n_meas;
    apb(1, A_CTRL, 32'h62);
    pins(1, 1);
    wait_st(3'h2);
    chk("target", freq_target, 16'd400);
    for (i = 0; i < 2000 && at_speed !== 1'b1; i++) step(1);
    for (n = 0; n < 200 && !(meas_req.valid === 1'b1 && meas_req.kind === K_LS); n++) step(1);
    chk("hold", n >= 20 && n <= 23, 1);
    wait_st(3'h6);
    chk("rot count", pm.n_meas - n0, 5);
    apb(0, A_MEAS1, 0);
    chk("ls", rdata[31:16], 16'h0144);
    apb(0, A_CURR, 0);
    chk("pf", rdata[23:16], 8'hDD);
    apb(0, A_IOUT, 0);
    chk("iout", rdata, 32'h008700E7);
    pins(1, 0);
    apb(1, A_CTRL, 32'h42);
    wait_st(3'h0);
    tune(32'h61);
    apb(1, A_CTRL, 32'h1E1);
    wait_st(3'h0);
  endtask
  task automatic t_once;
    apb(1, A_RS, 0);
    apb(1, A_CTRL, 32'h6C);
    n0 = pm.n_meas;
    n = nv_cnt;
    meas_fail <= 1'b1;
    pins(1, 1);
    pins(1, 0);
    for (i = 0; i < 100 && pm.n_meas == n0; i++) step(1);
    meas_fail <= 1'b0;
    wait_st(3'h0);
    apb(0, A_CTRL, 0);
    chk("mode kept", rdata[4:2], 3'h3);
    chk("no save", nv_cnt, n);
    pins(1, 1);
    wait_st(3'h5);
    apb(0, A_CTRL, 0);
    chk("mode switched", rdata[4:2], 3'h1);
    apb(0, A_RS, 0);
    chk("rs saved", rdata, 32'h0100);
    chk("save pulse", nv_cnt, n + 1);
    pins(1, 0);
    wait_st(3'h0);
    n0 = pm.n_meas;
    pins(1, 1);
    wait_st(3'h5);
    chk("manual", pm.n_meas, n0);
  endtask
  task automatic t_every;
    pins(1, 0);
    apb(1, A_CTRL, 32'h60);
    apb(1, A_RS, 0);
    step(30);
    n0 = pm.n_meas;
    n = nv_cnt;
    pins(1, 1);
    wait_st(3'h5);
    chk("every meas", pm.n_meas, n0 + 1);
    apb(0, A_RS, 0);
    chk("every rs", rdata, 32'h0100);
    pins(1, 0);
    step(2);
    pins(1, 1);
    wait_st(3'h5);
    chk("skip", pm.n_meas, n0 + 1);
    chk("every no save", nv_cnt, n);
  endtask
  task automatic t_volts;
    apb(1, A_RS, 0);
    apb(1, A_CTRL, 32'h64);
    jog <= 1'b1;
    pins(1, 1);
    wait_st(3'h5);
    foreach (vtab[k])
    begin
      apb(1, A_CTRL, 32'h60 | (vtab[k][38:36] << 2));
      f_ref <= 16'(vtab[k][35:24]);
      step(5);
      chk("v_out", v_out, vtab[k][23:12]);
      chk("rs_gain", rs_gain, vtab[k][11:0]);
    end
    jog <= 1'b0;
    pins(0, 0);
  endtask
  task automatic t_slip;
    logic [15:0] sync [4] = '{16'd3000, 16'd1500, 16'd1000, 16'd750};
    for (int p = 0; p < 4; p++)
    begin
      apb(1, A_RATED, {sync[p], 16'd500});
      apb(1, A_MOTOR, {16'h1400 | 16'(p * 2 + 2), 16'h0190});
      step(3);
      chk("slip sync", slip_on, 0);
    end
    apb(1, A_RATED, {16'd735, 16'd500});
    step(3);
    chk("slip on", slip_on, 1);
    apb(0, A_VOUT, 0);
    chk("slip hz", rdata[31:16], 16'd10);
    apb(1, A_CTRL, 32'h24);
    step(3);
    chk("slip bit", slip_on, 0);
    apb(1, A_CTRL, 32'h64);
    apb(1, A_RATED, {16'd0, 16'd500});
    step(3);
    chk("slip zero", slip_on, 0);
  endtask
  task automatic t_pwrup;
    pins(0, 0);
    presetn <= 1'b0;
    step(20);
    presetn <= 1'b1;
    cfg(600, 1470);
    apb(1, A_CTRL, 32'h70);
    pins(1, 0);
    step(30);
    n0 = pm.n_meas;
    n = nv_cnt;
    for (int r = 0; r < 2; r++)
    begin
      pins(1, 1);
      wait_st(3'h5);
      chk("pwrup meas", pm.n_meas, n0 + 1);
      pins(1, 0);
      step(30);
    end
    chk("pwrup no save", nv_cnt, n);
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, enable_in, run_in, meas_fail, jog} = '0;
    {paddr, pwdata, f_ref, miscompares, comparisons, nv_cnt} = '0;
    step(20);
    presetn <= 1'b1;
    apb(0, A_CTRL, 0);
    chk("ctrl reset", rdata, 32'h040);
    apb(0, A_CURR, 0);
    chk("pf reset", rdata[23:16], 8'hD9);
    apb(1, 8'h30, 32'h1);
    chk("unmapped", rerr, 1);
    t_stat();
    t_rot();
    t_once();
    t_every();
    t_volts();
    t_slip();
    t_pwrup();
    stop_test();
  end
  // Run needs well under 30k cycles
  initial
  begin
    step(60000);
    miscompares++;
    stop_test();
  end
endmodule // drive_autotune_voltage_mode_test
`default_nettype wire
